// ---- logic/ipsc_cfg.svh ----
/*
  Offsets, field positions and reset values of the interrupt pending and
  under-service flag block. Assumes a 32-bit Avalon-MM slave with byte
  addresses, one register per aligned word.
*/
`ifndef IPSC_CFG_SVH
`define IPSC_CFG_SVH

// register byte offsets
`define IPSC_FLAG_CONTROL_OFS  4'h0
`define IPSC_IRQ_STATUS_OFS    4'h4
`define IPSC_IRQ_ENABLE_OFS    4'h8
`define IPSC_IRQ_CLEAR_OFS     4'hc

// field positions of interrupt_flag_control
`define IPSC_US_OP_HI          15
`define IPSC_US_OP_LO          14
`define IPSC_US_SEL_HI         13
`define IPSC_US_SEL_LO         8
`define IPSC_PEND_OP_HI        7
`define IPSC_PEND_OP_LO        6
`define IPSC_PEND_SEL_HI       5
`define IPSC_PEND_SEL_LO       0

// reset values
`define IPSC_FLAGS_RST         6'h00
`define IPSC_IRQ_RST           6'h00
`define IPSC_RDATA_RST         32'h0000_0000

`endif

// ---- logic/ipsc_pkg.sv ----
/*
  Types of the interrupt pending and under-service flag block.
  Assumes nothing of its surroundings.
*/
package ipsc_pkg;

  // operation code in bits 15..14 of a flag control write
  typedef enum logic [1:0] {
    US_NOP0  = 2'b00,
    US_NOP1  = 2'b01,
    US_CLEAR = 2'b10,
    US_SET   = 2'b11
  } under_service_operation_t;

  // operation code in bits 7..6 of a flag control write
  typedef enum logic [1:0] {
    PEND_NOP       = 2'b00,
    PEND_CLEAR_ALL = 2'b01,
    PEND_CLEAR     = 2'b10,
    PEND_SET       = 2'b11
  } pending_operation_t;

  // one bit per source, bit order as in the flag register
  typedef logic [5:0] source_vec_t;

endpackage

// ---- logic/interrupt_pending_service_ctrl.sv ----
/*
  Interrupt pending and under-service flags for six sources (receive
  status, receive data, transmit status, transmit data, I/O pin and
  miscellaneous), reached over an Avalon-MM slave with waitrequest, plus
  a sticky event status, enable and clear register feeding one level
  interrupt. Assumes source events come from logic on ref_clk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ipsc_cfg.svh"

module interrupt_pending_service_ctrl
  import ipsc_pkg::*;
#(
  parameter int NUM_SOURCES = 6
) (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // avalon-mm slave
  input  wire logic [3:0]             address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire logic [31:0]            writedata,
  input  wire logic [3:0]             byteenable,
  output logic      [31:0]            readdata,
  output logic                        waitrequest,
  // interrupt sources, one-cycle pulses
  input  wire logic [NUM_SOURCES-1:0] source_event,
  // flag state
  output logic      [NUM_SOURCES-1:0] pending_flag,
  output logic      [NUM_SOURCES-1:0] under_service_flag,
  // interrupt
  output logic                        irq
);

  ////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, answer on the second edge

  logic        ack;
  logic        next_ack;
  logic [31:0] next_readdata;
  logic        access;
  logic        wr_take;

  logic [NUM_SOURCES-1:0] irq_status;
  logic [NUM_SOURCES-1:0] irq_enable;

  assign access      = read | write;
  assign waitrequest = access & ~ack;
  assign wr_take     = write & ack;

  always_comb begin
    next_ack      = access & ~ack;
    next_readdata = readdata;
    if (read && !ack) begin
      next_readdata = `IPSC_RDATA_RST;
      unique case (address)
        `IPSC_FLAG_CONTROL_OFS: begin
          // op fields read as zero
          next_readdata[`IPSC_US_SEL_HI:`IPSC_US_SEL_LO] =
            under_service_flag;
          next_readdata[`IPSC_PEND_SEL_HI:`IPSC_PEND_SEL_LO] =
            pending_flag;
        end
        `IPSC_IRQ_STATUS_OFS: begin
          next_readdata[NUM_SOURCES-1:0] = irq_status;
        end
        `IPSC_IRQ_ENABLE_OFS: begin
          next_readdata[NUM_SOURCES-1:0] = irq_enable;
        end
        default: begin
          next_readdata = `IPSC_RDATA_RST;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ack      <= 1'b0;
      readdata <= `IPSC_RDATA_RST;
    end else begin
      ack      <= next_ack;
      readdata <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flag control write decode

  logic                     ctl_wr_lo;
  logic                     ctl_wr_hi;
  under_service_operation_t us_op;
  pending_operation_t       pend_op;
  source_vec_t              us_sel;
  source_vec_t              pend_sel;
  logic [NUM_SOURCES-1:0]   us_set;
  logic [NUM_SOURCES-1:0]   us_clr;
  logic [NUM_SOURCES-1:0]   pend_set;
  logic [NUM_SOURCES-1:0]   pend_clr;

  assign ctl_wr_lo = wr_take && (address == `IPSC_FLAG_CONTROL_OFS) &&
                     byteenable[0];
  assign ctl_wr_hi = wr_take && (address == `IPSC_FLAG_CONTROL_OFS) &&
                     byteenable[1];
  assign us_op     = under_service_operation_t'(
                       writedata[`IPSC_US_OP_HI:`IPSC_US_OP_LO]);
  assign pend_op   = pending_operation_t'(
                       writedata[`IPSC_PEND_OP_HI:`IPSC_PEND_OP_LO]);
  assign us_sel    = writedata[`IPSC_US_SEL_HI:`IPSC_US_SEL_LO];
  assign pend_sel  = writedata[`IPSC_PEND_SEL_HI:`IPSC_PEND_SEL_LO];

  always_comb begin
    us_set   = '0;
    us_clr   = '0;
    pend_set = '0;
    pend_clr = '0;
    // op code acts only in the write that carries it
    if (ctl_wr_hi) begin
      unique case (us_op)
        US_NOP0,
        US_NOP1: begin
          us_set = '0;
        end
        US_CLEAR: begin
          us_clr = us_sel;
        end
        US_SET: begin
          us_set = us_sel;
        end
      endcase
    end
    if (ctl_wr_lo) begin
      unique case (pend_op)
        PEND_NOP: begin
          pend_set = '0;
        end
        PEND_CLEAR_ALL: begin
          pend_clr = pend_sel;
          us_clr   = us_clr | pend_sel;
        end
        PEND_CLEAR: begin
          pend_clr = pend_sel;
        end
        PEND_SET: begin
          pend_set = pend_sel;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pending and under-service flags

  logic [NUM_SOURCES-1:0] next_pending_flag;
  logic [NUM_SOURCES-1:0] next_under_service_flag;

  always_comb begin
    // a source event or a set beats a clear in the same cycle
    next_pending_flag = (pending_flag & ~pend_clr) | pend_set |
                        source_event;
    next_under_service_flag = (under_service_flag & ~us_clr) |
                              us_set;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pending_flag       <= `IPSC_FLAGS_RST;
      under_service_flag <= `IPSC_FLAGS_RST;
    end else begin
      pending_flag       <= next_pending_flag;
      under_service_flag <= next_under_service_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky event status, enable, write-one-to-clear, level interrupt

  logic [NUM_SOURCES-1:0] next_irq_status;
  logic [NUM_SOURCES-1:0] next_irq_enable;
  logic [NUM_SOURCES-1:0] irq_clr;
  logic                   next_irq;

  always_comb begin
    irq_clr         = '0;
    next_irq_enable = irq_enable;
    if (wr_take && byteenable[0]) begin
      if (address == `IPSC_IRQ_CLEAR_OFS) begin
        irq_clr = writedata[NUM_SOURCES-1:0];
      end
      if (address == `IPSC_IRQ_ENABLE_OFS) begin
        next_irq_enable = writedata[NUM_SOURCES-1:0];
      end
    end
    next_irq_status = (irq_status & ~irq_clr) | source_event;
    next_irq        = |(next_irq_status & next_irq_enable);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_status <= `IPSC_IRQ_RST;
      irq_enable <= `IPSC_IRQ_RST;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_enable <= next_irq_enable;
      irq        <= next_irq;
    end
  end

endmodule
`default_nettype wire

// ---- bench/ipsc_asserts.sv ----
/* port checker of the flag block, bound to every instance of it.
   assumes the master holds each request until waitrequest is low */
`timescale 1ns/1ns
`default_nettype none
module ipsc_asserts #(
  parameter int NUM_SOURCES = 6
) (
  // all ports of the block
  input wire logic                   ref_clk,
  input wire logic                   rst_n,
  input wire logic [3:0]             address,
  input wire logic                   read,
  input wire logic                   write,
  input wire logic [31:0]            writedata,
  input wire logic [3:0]             byteenable,
  input wire logic [31:0]            readdata,
  input wire logic                   waitrequest,
  input wire logic [NUM_SOURCES-1:0] source_event,
  input wire logic [NUM_SOURCES-1:0] pending_flag,
  input wire logic [NUM_SOURCES-1:0] under_service_flag,
  input wire logic                   irq
);
  logic       wr;
  logic       rd;
  logic [1:0] uo;
  logic [1:0] po;
  logic [5:0] s;
  logic [5:0] p;
  assign wr = write && !waitrequest && address == 4'h0;
  assign rd = read && !waitrequest && address == 4'h0;
  assign uo = writedata[15:14] & {2{byteenable[1]}};
  assign po = writedata[7:6] & {2{byteenable[0]}};
  assign s = writedata[13:8];
  assign p = writedata[5:0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_one_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("no answer after one wait");
  a_us_set: assert property (wr && uo == 2'b11 |=>
    (under_service_flag & $past(s)) == $past(s)) else $error("us set");
  a_us_clear: assert property (wr && uo == 2'b10 |=>
    (under_service_flag & $past(s)) == 6'h00) else $error("us clear");
  a_us_keep: assert property (wr && !uo[1] && po != 2'b01 |=>
    $stable(under_service_flag)) else $error("us changed");
  a_us_mask: assert property (wr && po != 2'b01 |=>
    ((under_service_flag ^ $past(under_service_flag)) & ~$past(s)) == 6'h00)
    else $error("us unselected changed");
  a_pend_set: assert property (wr && po == 2'b11 |=>
    (pending_flag & $past(p)) == $past(p)) else $error("pend set");
  a_pend_clear: assert property (wr && po[1] != po[0] |=>
    (pending_flag & $past(p) & ~$past(source_event)) == 6'h00)
    else $error("pend clear");
  a_both_clear: assert property (wr && po == 2'b01 && uo != 2'b11 |=>
    (under_service_flag & $past(p)) == 6'h00) else $error("us not cleared");
  a_pend_mask: assert property (wr |=> ((pending_flag ^
    $past(pending_flag)) & ~$past(p) & ~$past(source_event)) == 6'h00)
    else $error("pend unselected changed");
  a_op_zero: assert property (rd |->
    readdata[15:14] == 2'b00 && readdata[7:6] == 2'b00) else $error("op read");
  a_us_read: assert property (rd |->
    readdata[13:8] == under_service_flag) else $error("us read");
endmodule
bind interrupt_pending_service_ctrl ipsc_asserts #(
  .NUM_SOURCES(NUM_SOURCES)
) u_ipsc_asserts (.ref_clk, .rst_n, .address, .read, .write, .writedata,
  .byteenable, .readdata, .waitrequest, .source_event, .pending_flag,
  .under_service_flag, .irq);
`default_nettype wire

// ---- bench/tb.sv ----
/* self-checking bench of the flag block.
   assumes the checker is bound by its own file */
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [3:0]  address = 4'h0;
  logic [3:0]  byteenable = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic [5:0]  source_event = 6'h00;
  logic [31:0] readdata;
  logic [31:0] rd;
  logic        waitrequest;
  logic        irq;
  logic [5:0]  pending_flag;
  logic [5:0]  under_service_flag;
  int          num_errors = 0;
  int          compares = 0;
  int          cycles = 0;
  // write word, expected read word
  logic [31:0] rows [6] = '{32'hffff_3f3f, 32'h8581_3a3e, 32'h7f42_383c,
                            32'h3f0f_383c, 32'hc141_393c, 32'hb0c3_093f};
  always #5 ref_clk = ~ref_clk;
  interrupt_pending_service_ctrl u_interrupt_pending_service_ctrl (.ref_clk,
    .rst_n, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .source_event, .pending_flag, .under_service_flag, .irq);
  task end_sim;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d,
           input logic [3:0] be);
    @(posedge ref_clk);
    write <= w;
    read <= !w;
    address <= a;
    writedata <= d;
    byteenable <= be;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0) @(posedge ref_clk);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task pulse(input logic [5:0] e);
    @(posedge ref_clk);
    source_event <= e;
    @(posedge ref_clk);
    source_event <= 6'h00;
    @(posedge ref_clk);
  endtask
  function automatic logic [31:0] flags;
    return {18'h0, under_service_flag, 2'b00, pending_flag};
  endfunction
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 1000) begin
      num_errors++;
      end_sim();
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk({irq, readdata[30:0]} | flags(), 32'h0);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, 4'h0, {16'h0, rows[i][31:16]}, 4'h3);
      bus(1'b0, 4'h0, 32'h0, 4'hf);
      chk(rd, {16'h0, rows[i][15:0]});
      chk(flags(), {16'h0, rows[i][15:0]});
    end
    // lane 0 only: pending clear, under-service set ignored
    bus(1'b1, 4'h0, 32'hffbf, 4'h1);
    bus(1'b0, 4'h0, 32'h0, 4'hf);
    chk(rd, 32'h0900);
    bus(1'b1, 4'h8, 32'h3f, 4'hf);
    pulse(6'h04);
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, 4'h0, 32'h0, 4'hf);
    chk(rd, 32'h0904);
    bus(1'b1, 4'h4, 32'h0, 4'hf);
    bus(1'b1, 4'hc, 32'h4, 4'hf);
    // irq drops at the completion edge itself; look once it has settled
    @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 4'h8, 32'h0, 4'hf);
    pulse(6'h01);
    chk({31'h0, irq}, 32'h0);
    bus(1'b0, 4'h4, 32'h0, 4'hf);
    chk(rd, 32'h1);
    bus(1'b0, 4'hc, 32'h0, 4'hf);
    chk(rd, 32'h0);
    bus(1'b0, 4'h2, 32'h0, 4'hf);
    chk(rd, 32'h0);
    // second reset mid-run
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk(flags(), 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
